// File: hw/slcd_defines.svh
// constants for the segment lcd drive control block
`ifndef SLCD_DEFINES_SVH
`define SLCD_DEFINES_SVH

`define SLCD_ADDR_PDC 24'hFFFC30
`define SLCD_ADDR_DCTL 24'hFFFFC1
`define SLCD_ADDR_RAM_LO 24'hFFFC40
`define SLCD_RAM_BYTES 20
`define SLCD_PDC_RST 8'h00
`define SLCD_DCTL_RST 8'h00

`define SLCD_PDC_DUTY_HI 7
`define SLCD_PDC_DUTY_LO 6
`define SLCD_PDC_MERGE 5
`define SLCD_PDC_SEG_HI 3
`define SLCD_PDC_SEG_LO 0
`define SLCD_DCTL_DIVCON 6
`define SLCD_DCTL_ON 5
`define SLCD_DCTL_SHOW 4
`define SLCD_DCTL_FRM_HI 3
`define SLCD_DCTL_FRM_LO 0

`define SLCD_SEG_PINS 40
`define SLCD_COM_PINS 4
`define SLCD_SEG_GROUP 8
`define SLCD_SEG_CODE_MAX 4'h5
`define SLCD_SEG_CODE_UPPER 4'h3
`define SLCD_SEG_MASK_UPPER 40'hFFFFFF0000

`define SLCD_SUB_HZ 32768
`define SLCD_FRAME_HZ 64
`define SLCD_SRC_DIV_CODE1 2
`define SLCD_FRAME_SRC_TICKS ((`SLCD_SUB_HZ / `SLCD_SRC_DIV_CODE1) / `SLCD_FRAME_HZ)
`define SLCD_PHASE_LEN_1 9'h100
`define SLCD_PHASE_LEN_2 9'h080
`define SLCD_PHASE_LEN_3 9'h055
`define SLCD_PHASE_LEN_4 9'h040
`define SLCD_FRM_CODE_64HZ 4'h1

`endif

// File: hw/slcd_pkg.sv
// types shared by the segment lcd drive control block
package slcd_pkg;
  typedef enum logic [1:0] {DUTY_STATIC, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} slcd_duty_e;
  typedef enum logic {MODE_OFF, MODE_RUN} slcd_mode_e;
endpackage

// File: hw/slcd_frame_gen.sv
// frame timing: clock source prescaler, common phase and frame boundary
`timescale 1ns/1ns
`include "slcd_defines.svh"
module slcd_frame_gen #(
  parameter int MCLK_DIV = 16
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic sub_edge_i,
  input wire logic [3:0] frame_sel_i,
  input wire slcd_pkg::slcd_duty_e duty_i,
  output logic [1:0] phase_o,
  output logic frame_end_o
);
  if (MCLK_DIV < 1 || MCLK_DIV > 511) begin : g_bad_div
    $error("MCLK_DIV must lie in 1..511");
  end

  logic [15:0] pre_reg;
  logic [8:0] slot_reg;
  logic [1:0] phase_reg;
  logic src_tick;
  logic phase_end;

  // codes 0..7 divide the synchronised sub-clock by 2**code, 8..15 use the system clock
  function automatic logic [15:0] pre_limit(input logic [3:0] sel);
    if (sel[3])
      pre_limit = 16'((MCLK_DIV << sel[2:0]) - 1);
    else
      pre_limit = 16'((1 << sel[2:0]) - 1);
  endfunction

  // the 1/3 phase is rounded down, so such a frame is one tick short
  function automatic logic [8:0] phase_len(input slcd_pkg::slcd_duty_e d);
    case (d)
      slcd_pkg::DUTY_STATIC: phase_len = `SLCD_PHASE_LEN_1;
      slcd_pkg::DUTY_HALF: phase_len = `SLCD_PHASE_LEN_2;
      slcd_pkg::DUTY_THIRD: phase_len = `SLCD_PHASE_LEN_3;
      default: phase_len = `SLCD_PHASE_LEN_4;
    endcase
  endfunction

  assign src_tick = (frame_sel_i[3] || sub_edge_i) && pre_reg == pre_limit(frame_sel_i);
  assign phase_end = src_tick && slot_reg == phase_len(duty_i) - 9'h001;
  assign frame_end_o = phase_end && phase_reg == 2'(duty_i);
  assign phase_o = phase_reg;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      pre_reg <= 16'h0000;
    else if (!run_i || src_tick)
      pre_reg <= 16'h0000;
    else if (frame_sel_i[3] || sub_edge_i)
      pre_reg <= pre_reg + 16'h0001;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_reg <= 9'h000;
      phase_reg <= 2'h0;
    end else if (!run_i) begin
      slot_reg <= 9'h000;
      phase_reg <= 2'h0;
    end else if (phase_end) begin
      slot_reg <= 9'h000;
      phase_reg <= frame_end_o ? 2'h0 : phase_reg + 2'h1;
    end else if (src_tick) begin
      slot_reg <= slot_reg + 9'h001;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  chk_src_prescale: assert property (
    run_i && frame_sel_i == `SLCD_FRM_CODE_64HZ && src_tick
      |-> pre_reg == 16'(`SLCD_SRC_DIV_CODE1 - 1) && sub_edge_i)
    else $error("64 Hz source must be sub-clock divided by two");
  chk_frame_ticks: assert property (
    frame_end_o && duty_i == slcd_pkg::DUTY_QUARTER
      |-> 10'(slot_reg + 9'h001) * 10'h004 == 10'(`SLCD_FRAME_SRC_TICKS))
    else $error("quarter duty frame must span the 64 Hz tick count");
endmodule // slcd_frame_gen

// File: hw/slcd_drive_ctrl.sv
// segment lcd drive control: registers, display memory and electrode drive
`timescale 1ns/1ns
`include "slcd_defines.svh"
// Notes on behaviour
// - The duty field picks static, 1/2, 1/3 or 1/4 duty; code 11 scans all four commons.
// - With common merge set, commons unused by the duty repeat an active common, else idle.
// - The segment field picks driven pins; code 0011 drives pins 17..40, pins 1..16 are ports.
// - The divider-connect bit connects the supply divider resistors when one.
// - Controller off or standby keeps the divider resistors disconnected whatever the bit.
// - Controller-enable zero halts all drive and turns the drive supply off; one runs.
// - Turning the controller off leaves every register value unchanged.
// - Display-data bit zero blanks the segments; one shows display memory.
// - The frame field picks source and rate; code 0001 uses sub-clock/2 for a 64 Hz frame.
// - A memory bit of one lights its segment in its common phase, zero leaves it dark.
module slcd_drive_ctrl #(
  parameter int MCLK_DIV = 16
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [23:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sub_clk_i,
  input wire logic standby_i,
  output logic [`SLCD_SEG_PINS-1:0] seg_on_o,
  output logic [`SLCD_SEG_PINS-1:0] seg_drv_en_o,
  output logic [`SLCD_COM_PINS-1:0] com_sel_o,
  output logic [`SLCD_COM_PINS-1:0] com_drv_en_o,
  output logic divider_conn_o,
  output logic drive_supply_on_o
);
  logic [7:0] pin_duty_config_reg;
  logic [7:0] display_control_reg;
  logic [7:0] show_memory_mem [0:`SLCD_RAM_BYTES-1];
  logic [7:0] rdata_reg;
  logic sub_s1_reg;
  logic sub_s2_reg;
  logic sub_s3_reg;
  logic stby_s1_reg;
  logic stby_s2_reg;
  slcd_pkg::slcd_mode_e mode_reg;
  slcd_pkg::slcd_mode_e mode_next;
  slcd_pkg::slcd_duty_e duty_act_reg;
  logic merge_act_reg;
  logic [3:0] seg_sel_act_reg;
  logic [3:0] frame_sel_act_reg;
  logic [`SLCD_SEG_PINS-1:0] seg_on_reg;
  logic [`SLCD_SEG_PINS-1:0] seg_drv_en_reg;
  logic [`SLCD_COM_PINS-1:0] com_sel_reg;
  logic [`SLCD_COM_PINS-1:0] com_drv_en_reg;
  logic divider_conn_reg;
  logic drive_supply_reg;
  logic controller_on;
  logic show_memory;
  logic divider_connect;
  logic sub_edge;
  logic frame_end;
  logic cfg_load;
  logic [1:0] phase;
  logic [`SLCD_SEG_PINS-1:0] seg_pattern;
  logic [`SLCD_SEG_PINS-1:0] seg_mask;
  logic [`SLCD_COM_PINS-1:0] com_pattern;
  logic [`SLCD_COM_PINS-1:0] com_enable;

  function automatic logic in_ram(input logic [23:0] a);
    in_ram = a >= `SLCD_ADDR_RAM_LO && a < `SLCD_ADDR_RAM_LO + 24'(`SLCD_RAM_BYTES);
  endfunction

  function automatic logic [4:0] ram_idx(input logic [23:0] a);
    ram_idx = 5'(a - `SLCD_ADDR_RAM_LO);
  endfunction

  function automatic logic [2:0] com_count(input slcd_pkg::slcd_duty_e d);
    com_count = 3'(d) + 3'h1;
  endfunction

  assign controller_on = display_control_reg[`SLCD_DCTL_ON];
  assign show_memory = display_control_reg[`SLCD_DCTL_SHOW];
  assign divider_connect = display_control_reg[`SLCD_DCTL_DIVCON];

  // register writes are taken in every mode, so halting never disturbs them
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      pin_duty_config_reg <= `SLCD_PDC_RST;
    else if (wr_i && addr_i == `SLCD_ADDR_PDC)
      pin_duty_config_reg <= wdata_i;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      display_control_reg <= `SLCD_DCTL_RST;
    else if (wr_i && addr_i == `SLCD_ADDR_DCTL)
      display_control_reg <= wdata_i;
  end

  // display memory holds no reset so it can map to a plain ram
  always_ff @(posedge mclk_i) begin
    if (wr_i && in_ram(addr_i))
      show_memory_mem[ram_idx(addr_i)] <= wdata_i;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      rdata_reg <= 8'h00;
    else if (rd_i) begin
      if (addr_i == `SLCD_ADDR_PDC)
        rdata_reg <= pin_duty_config_reg;
      else if (addr_i == `SLCD_ADDR_DCTL)
        rdata_reg <= display_control_reg;
      else if (in_ram(addr_i))
        rdata_reg <= show_memory_mem[ram_idx(addr_i)];
      else
        rdata_reg <= 8'h00;
    end else
      rdata_reg <= 8'h00;
  end
  assign rdata_o = rdata_reg;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sub_s1_reg <= 1'b0;
      sub_s2_reg <= 1'b0;
      sub_s3_reg <= 1'b0;
    end else begin
      sub_s1_reg <= sub_clk_i;
      sub_s2_reg <= sub_s1_reg;
      sub_s3_reg <= sub_s2_reg;
    end
  end
  assign sub_edge = sub_s2_reg && !sub_s3_reg;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stby_s1_reg <= 1'b0;
      stby_s2_reg <= 1'b0;
    end else begin
      stby_s1_reg <= standby_i;
      stby_s2_reg <= stby_s1_reg;
    end
  end

  always_comb begin
    case (mode_reg)
      slcd_pkg::MODE_OFF: mode_next = controller_on ? slcd_pkg::MODE_RUN : slcd_pkg::MODE_OFF;
      slcd_pkg::MODE_RUN: mode_next = controller_on ? slcd_pkg::MODE_RUN : slcd_pkg::MODE_OFF;
      default: mode_next = slcd_pkg::MODE_OFF;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i)
      mode_reg <= slcd_pkg::MODE_OFF;
    else
      mode_reg <= mode_next;
  end

  // while halted the live fields pass straight through; once running they wait
  assign cfg_load = mode_reg == slcd_pkg::MODE_OFF || frame_end;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      duty_act_reg <= slcd_pkg::DUTY_STATIC;
      merge_act_reg <= 1'b0;
      seg_sel_act_reg <= 4'h0;
      frame_sel_act_reg <= 4'h0;
    end else if (cfg_load) begin
      duty_act_reg <= slcd_pkg::slcd_duty_e'(
        pin_duty_config_reg[`SLCD_PDC_DUTY_HI:`SLCD_PDC_DUTY_LO]);
      merge_act_reg <= pin_duty_config_reg[`SLCD_PDC_MERGE];
      seg_sel_act_reg <= pin_duty_config_reg[`SLCD_PDC_SEG_HI:`SLCD_PDC_SEG_LO];
      frame_sel_act_reg <= display_control_reg[`SLCD_DCTL_FRM_HI:`SLCD_DCTL_FRM_LO];
    end
  end

  slcd_frame_gen #(
    .MCLK_DIV(MCLK_DIV)
  ) u_frame (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .run_i(mode_reg == slcd_pkg::MODE_RUN),
    .sub_edge_i(sub_edge),
    .frame_sel_i(frame_sel_act_reg),
    .duty_i(duty_act_reg),
    .phase_o(phase),
    .frame_end_o(frame_end)
  );

  // byte n carries pin 2n+1 in the low nibble and pin 2n+2 in the high one, common 1 lowest
  always_comb begin
    seg_pattern = '0;
    seg_mask = '0;
    for (int k = 0; k < `SLCD_SEG_PINS; k++) begin
      seg_pattern[k] = show_memory_mem[k >> 1][((k & 1) * 4) + int'(phase)];
      if (seg_sel_act_reg > `SLCD_SEG_CODE_MAX)
        seg_mask[k] = 1'b1;
      else
        seg_mask[k] = k >= `SLCD_SEG_PINS - `SLCD_SEG_GROUP * int'(seg_sel_act_reg);
    end
  end

  always_comb begin
    com_pattern = '0;
    com_enable = '0;
    for (int i = 0; i < `SLCD_COM_PINS; i++) begin
      if (i < int'(com_count(duty_act_reg))) begin
        com_pattern[i] = i == int'(phase);
        com_enable[i] = 1'b1;
      end else begin
        com_pattern[i] = merge_act_reg && (i % int'(com_count(duty_act_reg))) == int'(phase);
        com_enable[i] = merge_act_reg;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seg_on_reg <= '0;
      seg_drv_en_reg <= '0;
      com_sel_reg <= '0;
      com_drv_en_reg <= '0;
    end else if (mode_reg != slcd_pkg::MODE_RUN) begin
      seg_on_reg <= '0;
      seg_drv_en_reg <= '0;
      com_sel_reg <= '0;
      com_drv_en_reg <= '0;
    end else begin
      seg_on_reg <= show_memory ? (seg_pattern & seg_mask) : '0;
      seg_drv_en_reg <= seg_mask;
      com_sel_reg <= com_pattern;
      com_drv_en_reg <= com_enable;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      divider_conn_reg <= 1'b0;
      drive_supply_reg <= 1'b0;
    end else begin
      divider_conn_reg <= controller_on && divider_connect && !stby_s2_reg;
      drive_supply_reg <= controller_on;
    end
  end

  assign seg_on_o = seg_on_reg;
  assign seg_drv_en_o = seg_drv_en_reg;
  assign com_sel_o = com_sel_reg;
  assign com_drv_en_o = com_drv_en_reg;
  assign divider_conn_o = divider_conn_reg;
  assign drive_supply_on_o = drive_supply_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence seq_running;
    mode_reg == slcd_pkg::MODE_RUN;
  endsequence

  sequence seq_pdc_write_mid_frame;
    seq_running ##0 (wr_i && addr_i == `SLCD_ADDR_PDC && !frame_end);
  endsequence

  chk_quarter_scan: assert property (
    seq_running ##0 duty_act_reg == slcd_pkg::DUTY_QUARTER && frame_end
      |-> phase == 2'h3)
    else $error("quarter duty frame must end after the fourth common");
  chk_unused_com: assert property (
    seq_running ##0 !merge_act_reg && duty_act_reg == slcd_pkg::DUTY_HALF && !cfg_load
      |=> com_drv_en_o == 4'h3 && com_sel_o[3:2] == 2'h0)
    else $error("unused commons must stay idle without merge");
  chk_merge_copy: assert property (
    seq_running ##0 merge_act_reg && duty_act_reg == slcd_pkg::DUTY_HALF && !cfg_load
      |=> com_sel_o[3:2] == com_sel_o[1:0] && com_drv_en_o == 4'hF)
    else $error("merged commons must repeat the active waveform");
  chk_seg_upper: assert property (
    seq_running ##0 seg_sel_act_reg == `SLCD_SEG_CODE_UPPER && !cfg_load
      |=> seg_drv_en_o == `SLCD_SEG_MASK_UPPER)
    else $error("code 0011 must drive pins 17 to 40 only");
  chk_divider_on: assert property (
    controller_on && divider_connect && !stby_s2_reg |=> divider_conn_o)
    else $error("divider must connect when enabled");
  chk_divider_off: assert property (
    !controller_on || stby_s2_reg |=> !divider_conn_o)
    else $error("divider must stay off while halted or in standby");
  chk_halt_quiet: assert property (
    !controller_on ##1 !controller_on
      |=> !drive_supply_on_o && com_sel_o == '0 && seg_on_o == '0 && seg_drv_en_o == '0)
    else $error("halted controller must drive nothing");
  chk_regs_kept: assert property (
    $fell(controller_on) && !wr_i |=> $stable(pin_duty_config_reg) ##0 !controller_on)
    else $error("halting must not disturb registers");
  chk_blank: assert property (
    !show_memory |=> seg_on_o == '0)
    else $error("blank mode must darken every segment");
  chk_seg_shows_mem: assert property (
    seq_running ##0 show_memory && seg_mask[`SLCD_SEG_PINS-1] && !cfg_load
      |=> seg_on_o[`SLCD_SEG_PINS-1] == $past(show_memory_mem[`SLCD_RAM_BYTES-1][4 + int'(phase)]))
    else $error("top segment must follow its memory bit");
  chk_frame_hold: assert property (
    seq_pdc_write_mid_frame |=> duty_act_reg == $past(duty_act_reg))
    else $error("duty change must wait for the frame boundary");
endmodule // slcd_drive_ctrl

// File: verif/slcd_panel_model.sv
// behavioural panel: keeps what each common last saw on the segment electrodes
`timescale 1ns/1ns
`include "slcd_defines.svh"
module slcd_panel_model (
  input wire logic mclk_i,
  input wire logic [`SLCD_SEG_PINS-1:0] seg_on_i,
  input wire logic [`SLCD_SEG_PINS-1:0] seg_drv_en_i,
  input wire logic [`SLCD_COM_PINS-1:0] com_sel_i,
  input wire logic drive_supply_on_i,
  output logic [`SLCD_SEG_PINS-1:0] image_o [`SLCD_COM_PINS]
);
  // merged commons are skipped so one image never mixes two phases
  always_ff @(posedge mclk_i) begin
    for (int c = 0; c < `SLCD_COM_PINS; c++) begin
      if (drive_supply_on_i && com_sel_i == 4'(1 << c)) begin
        image_o[c] <= seg_on_i & seg_drv_en_i;
      end
    end
  end
endmodule // slcd_panel_model

// File: verif/slcd_drive_ctrl_tb.sv
// self-checking bench for the segment lcd drive control block
`timescale 1ns/1ns
`include "slcd_defines.svh"
module slcd_drive_ctrl_tb;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [23:0] addr_i = 24'h000000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sub_clk_i = 1'b0;
  logic standby_i = 1'b0;
  logic [7:0] rdata_o;
  logic [39:0] seg_on_o;
  logic [39:0] seg_drv_en_o;
  logic [3:0] com_sel_o;
  logic [3:0] com_drv_en_o;
  logic divider_conn_o;
  logic drive_supply_on_o;
  logic [39:0] image [4];
  logic [2:0] sub_div = 3'h0;
  int failures = 0;
  int tests_run = 0;

  always #5 mclk_i = ~mclk_i;
  // sub-clock at 1/8 of mclk: a 64 Hz-code frame is then 4096 cycles
  always @(posedge mclk_i) begin
    sub_div <= sub_div + 3'h1;
    sub_clk_i <= sub_div[2];
  end

  slcd_drive_ctrl #(.MCLK_DIV(1)) dut_u (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sub_clk_i(sub_clk_i),
    .standby_i(standby_i), .seg_on_o(seg_on_o), .seg_drv_en_o(seg_drv_en_o),
    .com_sel_o(com_sel_o), .com_drv_en_o(com_drv_en_o),
    .divider_conn_o(divider_conn_o), .drive_supply_on_o(drive_supply_on_o)
  );
  slcd_panel_model panel_u (
    .mclk_i(mclk_i), .seg_on_i(seg_on_o), .seg_drv_en_i(seg_drv_en_o),
    .com_sel_i(com_sel_o), .drive_supply_on_i(drive_supply_on_o), .image_o(image)
  );

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic bus_rd(input logic [23:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wait_com1(output time t);
    int i;
    i = 0;
    @(posedge mclk_i);
    while (com_sel_o[0] !== 1'b0 && i < 9000) begin
      @(posedge mclk_i);
      i++;
    end
    while (com_sel_o[0] !== 1'b1 && i < 9000) begin
      @(posedge mclk_i);
      i++;
    end
    t = $time;
    chk_out(40'(i < 9000), 40'h1);
  endtask

  task automatic t_regs();
    logic [7:0] d;
    bus_rd(`SLCD_ADDR_PDC, d);
    chk_reg(d, `SLCD_PDC_RST);
    bus_rd(`SLCD_ADDR_DCTL, d);
    chk_reg(d, `SLCD_DCTL_RST);
    bus_wr(`SLCD_ADDR_PDC, 8'hA5);
    bus_wr(`SLCD_ADDR_DCTL, 8'h5B);
    bus_wr(24'hFFFC31, 8'hFF);
    bus_rd(24'hFFFC31, d);
    chk_reg(d, 8'h00);
    bus_rd(`SLCD_ADDR_PDC, d);
    chk_reg(d, 8'hA5);
    bus_rd(`SLCD_ADDR_DCTL, d);
    chk_reg(d, 8'h5B);
    // display memory has no reset; fill it before any scan reads it
    for (int n = 0; n < `SLCD_RAM_BYTES; n++) begin
      bus_wr(`SLCD_ADDR_RAM_LO + 24'(n), 8'(n + 1));
    end
    bus_rd(`SLCD_ADDR_RAM_LO + 24'(`SLCD_RAM_BYTES - 1), d);
    chk_reg(d, 8'h14);
  endtask
  task automatic t_act();
    logic [7:0] d;
    bus_wr(`SLCD_ADDR_PDC, 8'hCF);
    for (int i = 0; i < 8; i++) begin
      bus_wr(`SLCD_ADDR_DCTL, {1'b0, i[1], i[0], 5'h18});
      standby_i <= i[2];
      repeat (6) @(posedge mclk_i);
      chk_out(40'(divider_conn_o), 40'(i[0] & i[1] & ~i[2]));
      chk_out(40'(drive_supply_on_o), 40'(i[0]));
      if (!i[0]) begin
        chk_out({com_sel_o, seg_drv_en_o[35:0]}, 40'h0);
      end
      bus_rd(`SLCD_ADDR_DCTL, d);
      chk_reg(d, {1'b0, i[1], i[0], 5'h18});
      bus_rd(`SLCD_ADDR_PDC, d);
      chk_reg(d, 8'hCF);
    end
    standby_i <= 1'b0;
  endtask
  task automatic t_duty();
    logic [3:0] seen;
    logic bad;
    int n;
    for (int m = 0; m < 8; m++) begin
      n = m[1:0] + 1;
      bus_wr(`SLCD_ADDR_DCTL, 8'h18);
      bus_wr(`SLCD_ADDR_PDC, {m[1:0], m[2], 5'h0F});
      bus_wr(`SLCD_ADDR_DCTL, 8'h38);
      repeat (20) @(posedge mclk_i);
      seen = 4'h0;
      bad = 1'b0;
      repeat (600) begin
        @(posedge mclk_i);
        seen |= com_sel_o;
        for (int c = 0; c < 4; c++) begin
          if (m[2] && com_sel_o[c] !== com_sel_o[c % n]) bad = 1'b1;
        end
      end
      chk_reg(8'(seen), m[2] ? 8'h0F : 8'((1 << n) - 1));
      chk_reg(8'(bad), 8'h00);
      chk_reg(8'(com_drv_en_o), m[2] ? 8'h0F : 8'((1 << n) - 1));
    end
  endtask
  task automatic t_seg();
    logic [39:0] prev;
    logic [39:0] exp;
    time t;
    prev = {40{1'b1}};
    for (int k = 0; k < 16; k++) begin
      exp = (k == 0) ? 40'h0 : (k > 5) ? {40{1'b1}} : {40{1'b1}} << (40 - 8 * k);
      wait_com1(t);
      bus_wr(`SLCD_ADDR_PDC, {4'hC, k[3:0]});
      repeat (5) @(posedge mclk_i);
      chk_out(seg_drv_en_o, prev);
      repeat (300) @(posedge mclk_i);
      chk_out(seg_drv_en_o, exp);
      prev = exp;
    end
  endtask
  task automatic t_mem();
    logic [7:0] b;
    logic [39:0] exp;
    bus_wr(`SLCD_ADDR_PDC, 8'hCF);
    for (int n = 0; n < 20; n++) begin
      bus_wr(`SLCD_ADDR_RAM_LO + 24'(n), 8'(n * 37 + 11));
    end
    repeat (600) @(posedge mclk_i);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 40; k++) begin
        b = 8'((k / 2) * 37 + 11);
        exp[k] = b[(k % 2) * 4 + c];
      end
      chk_out(image[c], exp);
    end
    // blanking is immediate, so the pins are checked before a frame passes
    bus_wr(`SLCD_ADDR_DCTL, 8'h28);
    repeat (3) @(posedge mclk_i);
    chk_out(seg_on_o, 40'h0);
    repeat (600) @(posedge mclk_i);
    chk_out(image[2], 40'h0);
  endtask
  task automatic t_frame();
    time t0;
    time t1;
    bus_wr(`SLCD_ADDR_DCTL, 8'h11);
    bus_wr(`SLCD_ADDR_DCTL, 8'h31);
    // the first frame after enable is not aligned to the source ticks, so skip it
    wait_com1(t0);
    wait_com1(t0);
    wait_com1(t1);
    chk_out(40'((t1 - t0) / 10), 40'h1000);
  endtask

  task automatic wrap_up();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // the whole run needs about 23k cycles; the limit leaves ample margin
  initial begin
    #500000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_act();
    t_duty();
    t_seg();
    t_mem();
    t_frame();
    wrap_up();
  end
endmodule // slcd_drive_ctrl_tb
